// ===== common/rcodiv_params.svh
// register offsets, field positions and reset values for the reference clock divider
// assumes a 16-bit register port with word indices 0..2
`ifndef RCODIV_PARAMS_SVH
`define RCODIV_PARAMS_SVH
`define RCODIV_ADDR_W 4
`define RCODIV_OFF_CTRL_LOW 4'h0
`define RCODIV_OFF_DIV_HIGH 4'h1
`define RCODIV_OFF_TRIM 4'h2
`define RCODIV_BIT_MODULE_ENABLE 15
`define RCODIV_BIT_STOP_IN_IDLE 13
`define RCODIV_BIT_PIN_OUTPUT_ENABLE 12
`define RCODIV_BIT_RUN_IN_SLEEP 11
`define RCODIV_BIT_SWITCH_ENABLE 9
`define RCODIV_BIT_REQUEST_STATUS 8
`define RCODIV_CTRL_WMASK 16'hb80f
`define RCODIV_TRIM_WMASK 16'hff80
`define RCODIV_DIV_WMASK 16'h7fff
`define RCODIV_RESET_VALUE 16'h0000
`define RCODIV_FRAC_ONE 10'h200
`endif

// ===== common/rcodiv_pkg.sv
// types shared by the reference clock divider
// no assumptions beyond a SystemVerilog tool
package rcodiv_pkg;
  // base clock source encodings
  typedef enum logic [3:0] {
    RCODIV_SRC_SYSTEM = 4'h0,
    RCODIV_SRC_PERIPH = 4'h1,
    RCODIV_SRC_PRIMARY = 4'h2,
    RCODIV_SRC_FAST_RC = 4'h3,
    RCODIV_SRC_LOW_POWER_RC = 4'h4,
    RCODIV_SRC_SECONDARY = 4'h5,
    RCODIV_SRC_PLL8X = 4'h6,
    RCODIV_SRC_RESERVED = 4'h7
  } rcodiv_src_e;
  // enable handshake states, one-hot
  typedef enum logic [2:0] {
    RCODIV_ST_OFF = 3'h1,
    RCODIV_ST_ON = 3'h2,
    RCODIV_ST_STOP = 3'h4
  } rcodiv_state_e;
endpackage : rcodiv_pkg

// ===== core/rcodiv_top.sv
// reference clock output divider: source mux, 15-bit divider, 9-bit fraction trim
// assumes base clocks arrive as one-cycle enable pulses synchronous to ref_clk_i
// Summary of operation
// - generator runs while module_enable set, then until output low
// - pin carries clock only with output enable
// - fifteen-bit integer divider in high register
// - four-bit field picks the base clock
// - request status tracks turn-on and turn-off
// - status clears only after glitch-free output stop
// - switch-enable applies new divider, then self-clears
// - zero passes through; here zero toggles on every tick instead; else period twice divisor
// - trim adds n/512 to half period
// - trim ignored when divider is zero
// - sleep keeps output only with run_in_sleep
// - oscillators power down in sleep unless kept
//
// Implementation choices: strobed register access and the address map.
`timescale 1ns/10ps
`include "rcodiv_params.svh"
module rcodiv_top (
  input wire logic ref_clk_i, // 10 MHz core clock
  input wire logic rstn_i, // synchronous, active low
  input wire logic [`RCODIV_ADDR_W-1:0] addr_i, // register word index
  input wire logic [15:0] wdata_i, // write data
  input wire logic wr_i, // write strobe
  input wire logic rd_i, // read strobe
  output logic [15:0] rdata_o, // read data, cycle after rd_i
  input wire logic [7:0] src_tick_i, // base clock ticks, one per encoding 0..7
  input wire logic idle_i, // device in idle
  input wire logic sleep_i, // device in sleep
  input wire logic primary_osc_keep_enable_i, // primary oscillator kept in sleep
  input wire logic secondary_osc_keep_enable_i, // secondary oscillator kept in sleep
  output logic reference_output_pin_o, // generated clock on the pin
  output logic reference_output_pin_oe_o // pin driven
);
  // software registers
  logic module_enable_reg, module_enable_next;
  logic stop_in_idle_reg, stop_in_idle_next;
  logic pin_output_enable_reg, pin_output_enable_next;
  logic run_in_sleep_reg, run_in_sleep_next;
  logic switch_enable_reg, switch_enable_next;
  logic [3:0] src_sel_reg, src_sel_next;
  logic [14:0] int_div_reg, int_div_next; // shadow written by software
  logic [8:0] trim_reg, trim_next;
  logic [15:0] rdata_reg, rdata_next;
  // divider working state
  rcodiv_pkg::rcodiv_state_e state_reg, state_next;
  logic [14:0] act_div_reg, act_div_next; // divider in use
  logic [8:0] act_trim_reg, act_trim_next;
  logic [14:0] cnt_reg, cnt_next; // base ticks in current half period
  logic [9:0] acc_reg, acc_next; // fraction accumulator in 1/512
  logic out_reg, out_next; // divided clock level
  logic pin_reg, pin_next;
  logic pin_oe_reg, pin_oe_next;
  // derived terms
  logic tick; // selected base tick
  logic src_alive; // source survives current power mode
  logic run; // generator allowed to advance
  logic half_end; // half period finished at this tick
  logic [9:0] acc_sum;
  logic [15:0] half_len; // one bit wider than the divider
  logic [15:0] ctrl_view;

  // mux of base ticks; the reserved code gives a dead source
  // a zero divider toggles on every tick: ticks carry no duty cycle of their own
  always_comb begin
    tick = 1'b0;
    case (src_sel_reg)
      4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6: tick = src_tick_i[src_sel_reg[2:0]];
      default: tick = 1'b0;
    endcase
  end

  // sleep kills the clock unless run_in_sleep is set and, for primary or secondary, that oscillator is kept; system and peripheral always stop
  // fast rc, low-power rc and pll follow run_in_sleep alone, as on-chip sources
  always_comb begin
    src_alive = 1'b1;
    if (sleep_i) begin
      case (src_sel_reg)
        4'h2: src_alive = run_in_sleep_reg & primary_osc_keep_enable_i;
        4'h5: src_alive = run_in_sleep_reg & secondary_osc_keep_enable_i;
        4'h4: src_alive = run_in_sleep_reg;
        4'h3, 4'h6: src_alive = run_in_sleep_reg;
        default: src_alive = 1'b0;
      endcase
    end
  end

  // idle stop and sleep gate the generator
  assign run = src_alive & ~(idle_i & stop_in_idle_reg);

  // a half period is act_div ticks plus one more whenever trim fraction overflows
  // the top divider plus a stretch tick must not wrap to a zero length
  assign acc_sum = acc_reg + {1'b0, act_trim_reg};
  assign half_len = (acc_sum >= `RCODIV_FRAC_ONE) ? {1'b0, act_div_reg} + 16'h0001 :
    {1'b0, act_div_reg};
  assign half_end = ({1'b0, cnt_reg} + 16'h0001 >= half_len);

  // divider, handshake and switch next state
  always_comb begin
    state_next = state_reg;
    act_div_next = act_div_reg;
    act_trim_next = act_trim_reg;
    cnt_next = cnt_reg;
    acc_next = acc_reg;
    out_next = out_reg;
    case (state_reg)
      rcodiv_pkg::RCODIV_ST_OFF: begin
        out_next = 1'b0;
        cnt_next = 15'h0000;
        acc_next = 10'h000;
        if (module_enable_reg) begin
          state_next = rcodiv_pkg::RCODIV_ST_ON;
          act_div_next = int_div_reg;
          act_trim_next = trim_reg;
        end
      end
      rcodiv_pkg::RCODIV_ST_ON, rcodiv_pkg::RCODIV_ST_STOP: begin
        if (run && tick) begin
          if (act_div_reg == 15'h0000) begin
            out_next = ~out_reg;
            cnt_next = 15'h0000; // trim not used here
            // a pending switch must land here too, or the bit would never clear
            if (switch_enable_reg && out_reg) begin
              act_div_next = int_div_reg;
              act_trim_next = trim_reg;
              acc_next = 10'h000; // fresh fraction phase for the new setting
            end
          end else if (half_end) begin
            out_next = ~out_reg;
            cnt_next = 15'h0000;
            acc_next = (acc_sum >= `RCODIV_FRAC_ONE) ? acc_sum - `RCODIV_FRAC_ONE : acc_sum;
            // new values only at a low-going edge boundary keep the output clean
            if (switch_enable_reg && out_reg) begin
              act_div_next = int_div_reg;
              act_trim_next = trim_reg;
            end
          end else begin
            cnt_next = cnt_reg + 15'h0001;
          end
        end
        if (!module_enable_reg) begin
          state_next = rcodiv_pkg::RCODIV_ST_STOP;
        end
        // stop only when output is already low, so the last high phase is whole
        if (state_reg == rcodiv_pkg::RCODIV_ST_STOP || !module_enable_reg) begin
          if (!out_reg) begin
            state_next = rcodiv_pkg::RCODIV_ST_OFF;
            // a tick in this very cycle must not raise a runt high pulse
            out_next = 1'b0;
          end else if (module_enable_reg) begin
            state_next = rcodiv_pkg::RCODIV_ST_ON;
          end
        end
      end
      default: begin
        state_next = rcodiv_pkg::RCODIV_ST_OFF;
      end
    endcase
  end

  // switch completes when act_* update; pins follow output and enable
  always_comb begin
    pin_oe_next = pin_output_enable_reg;
    pin_next = pin_output_enable_reg & out_next;
  end

  // register view of the low control word
  always_comb begin
    ctrl_view = 16'h0000;
    ctrl_view[`RCODIV_BIT_MODULE_ENABLE] = module_enable_reg;
    ctrl_view[`RCODIV_BIT_STOP_IN_IDLE] = stop_in_idle_reg;
    ctrl_view[`RCODIV_BIT_PIN_OUTPUT_ENABLE] = pin_output_enable_reg;
    ctrl_view[`RCODIV_BIT_RUN_IN_SLEEP] = run_in_sleep_reg;
    ctrl_view[`RCODIV_BIT_SWITCH_ENABLE] = switch_enable_reg;
    // status is the handshake state, so software sees the stop actually finish
    ctrl_view[`RCODIV_BIT_REQUEST_STATUS] = (state_reg != rcodiv_pkg::RCODIV_ST_OFF);
    ctrl_view[3:0] = src_sel_reg;
  end

  // register writes, reads and hardware clear of switch enable
  always_comb begin
    module_enable_next = module_enable_reg;
    stop_in_idle_next = stop_in_idle_reg;
    pin_output_enable_next = pin_output_enable_reg;
    run_in_sleep_next = run_in_sleep_reg;
    switch_enable_next = switch_enable_reg;
    src_sel_next = src_sel_reg;
    int_div_next = int_div_reg;
    trim_next = trim_reg;
    rdata_next = 16'h0000;
    // switch done once the working divider matches, or while off
    // a zero written to the switch bit is ignored, only this clears it
    if (switch_enable_reg && (state_reg == rcodiv_pkg::RCODIV_ST_OFF ||
        (act_div_reg == int_div_reg && act_trim_reg == trim_reg))) begin
      switch_enable_next = 1'b0;
    end
    if (wr_i) begin
      case (addr_i)
        `RCODIV_OFF_CTRL_LOW: begin
          module_enable_next = wdata_i[`RCODIV_BIT_MODULE_ENABLE];
          stop_in_idle_next = wdata_i[`RCODIV_BIT_STOP_IN_IDLE];
          pin_output_enable_next = wdata_i[`RCODIV_BIT_PIN_OUTPUT_ENABLE];
          run_in_sleep_next = wdata_i[`RCODIV_BIT_RUN_IN_SLEEP];
          // software may only set it; a set beats the hardware clear
          if (wdata_i[`RCODIV_BIT_SWITCH_ENABLE]) begin
            switch_enable_next = 1'b1;
          end
          // source held while the request is active
          if (!ctrl_view[`RCODIV_BIT_REQUEST_STATUS]) begin
            src_sel_next = wdata_i[3:0];
          end
        end
        `RCODIV_OFF_DIV_HIGH: int_div_next = wdata_i[14:0];
        `RCODIV_OFF_TRIM: trim_next = wdata_i[15:7];
        default: ;
      endcase
    end
    if (rd_i) begin
      case (addr_i)
        `RCODIV_OFF_CTRL_LOW: rdata_next = ctrl_view;
        `RCODIV_OFF_DIV_HIGH: rdata_next = {1'b0, int_div_reg};
        `RCODIV_OFF_TRIM: rdata_next = {trim_reg, 7'h00};
        default: rdata_next = 16'h0000; // unmapped reads zero
      endcase
    end
  end

  // all state registered here
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      module_enable_reg <= 1'b0;
      stop_in_idle_reg <= 1'b0;
      pin_output_enable_reg <= 1'b0;
      run_in_sleep_reg <= 1'b0;
      switch_enable_reg <= 1'b0;
      src_sel_reg <= 4'h0;
      int_div_reg <= 15'h0000;
      trim_reg <= 9'h000;
      rdata_reg <= `RCODIV_RESET_VALUE;
      state_reg <= rcodiv_pkg::RCODIV_ST_OFF;
      act_div_reg <= 15'h0000;
      act_trim_reg <= 9'h000;
      cnt_reg <= 15'h0000;
      acc_reg <= 10'h000;
      out_reg <= 1'b0;
      pin_reg <= 1'b0;
      pin_oe_reg <= 1'b0;
    end else begin
      module_enable_reg <= module_enable_next;
      stop_in_idle_reg <= stop_in_idle_next;
      pin_output_enable_reg <= pin_output_enable_next;
      run_in_sleep_reg <= run_in_sleep_next;
      switch_enable_reg <= switch_enable_next;
      src_sel_reg <= src_sel_next;
      int_div_reg <= int_div_next;
      trim_reg <= trim_next;
      rdata_reg <= rdata_next;
      state_reg <= state_next;
      act_div_reg <= act_div_next;
      act_trim_reg <= act_trim_next;
      cnt_reg <= cnt_next;
      acc_reg <= acc_next;
      out_reg <= out_next;
      pin_reg <= pin_next;
      pin_oe_reg <= pin_oe_next;
    end
  end

  assign rdata_o = rdata_reg;
  assign reference_output_pin_o = pin_reg;
  assign reference_output_pin_oe_o = pin_oe_reg;

  // checks
  // all on the core clock and quiet during reset
  property p_off_no_toggle;
    @(posedge ref_clk_i) disable iff (!rstn_i)
      (state_reg == rcodiv_pkg::RCODIV_ST_OFF) |=> !out_reg;
  endproperty
  a_off_no_toggle: assert property (p_off_no_toggle) else $error("output high while off");
  property p_pin_gated;
    @(posedge ref_clk_i) disable iff (!rstn_i)
      !pin_output_enable_reg |=> !reference_output_pin_o;
  endproperty
  a_pin_gated: assert property (p_pin_gated) else $error("pin active without enable");
  property p_status_clear_low;
    @(posedge ref_clk_i) disable iff (!rstn_i)
      $fell(ctrl_view[`RCODIV_BIT_REQUEST_STATUS]) |-> !out_reg;
  endproperty
  a_status_clear_low: assert property (p_status_clear_low) else $error("stop while high");
  property p_src_hold;
    @(posedge ref_clk_i) disable iff (!rstn_i)
      ctrl_view[`RCODIV_BIT_REQUEST_STATUS] |=> $stable(src_sel_reg);
  endproperty
  a_src_hold: assert property (p_src_hold) else $error("source changed while active");
  property p_bypass;
    @(posedge ref_clk_i) disable iff (!rstn_i)
      (state_reg == rcodiv_pkg::RCODIV_ST_ON && module_enable_reg && act_div_reg == 15'h0000
       && run && tick) |=> (out_reg != $past(out_reg));
  endproperty
  a_bypass: assert property (p_bypass) else $error("no toggle in bypass");
  property p_sleep_stop;
    @(posedge ref_clk_i) disable iff (!rstn_i)
      (sleep_i && !run_in_sleep_reg) |=> $stable(out_reg);
  endproperty
  a_sleep_stop: assert property (p_sleep_stop) else $error("output ran in sleep");
  property p_idle_stop;
    @(posedge ref_clk_i) disable iff (!rstn_i)
      (idle_i && stop_in_idle_reg && module_enable_reg) |=> $stable(out_reg);
  endproperty
  a_idle_stop: assert property (p_idle_stop) else $error("output ran in idle");
  property p_switch_clear;
    @(posedge ref_clk_i) disable iff (!rstn_i)
      (switch_enable_reg && state_reg == rcodiv_pkg::RCODIV_ST_OFF && !wr_i) |=> !switch_enable_reg;
  endproperty
  a_switch_clear: assert property (p_switch_clear) else $error("switch bit stuck");
  property p_peri_sleep;
    @(posedge ref_clk_i) disable iff (!rstn_i)
      (sleep_i && src_sel_reg == 4'h1) |-> !run;
  endproperty
  a_peri_sleep: assert property (p_peri_sleep) else $error("peripheral source ran in sleep");
  // no runt pulse reaches the pin once the generator is off
  property p_off_pin_low;
    @(posedge ref_clk_i) disable iff (!rstn_i)
      (state_reg == rcodiv_pkg::RCODIV_ST_OFF) |-> !reference_output_pin_o;
  endproperty
  a_off_pin_low: assert property (p_off_pin_low) else $error("pin high while off");
  // setting the enable raises the request status on the next cycle
  property p_status_on;
    @(posedge ref_clk_i) disable iff (!rstn_i)
      $rose(module_enable_reg) |=> ctrl_view[`RCODIV_BIT_REQUEST_STATUS];
  endproperty
  a_status_on: assert property (p_status_on) else $error("status not raised");
  c_turn_on: cover property (@(posedge ref_clk_i) disable iff (!rstn_i)
    $rose(ctrl_view[`RCODIV_BIT_REQUEST_STATUS]));
  c_turn_off: cover property (@(posedge ref_clk_i) disable iff (!rstn_i)
    $fell(ctrl_view[`RCODIV_BIT_REQUEST_STATUS]));
  c_switch: cover property (@(posedge ref_clk_i) disable iff (!rstn_i) $fell(switch_enable_reg));
  // fraction stretch and sleep running both reached
  c_trim_stretch: cover property (@(posedge ref_clk_i) disable iff (!rstn_i)
    run && tick && half_end && act_div_reg != 15'h0000 && acc_sum >= `RCODIV_FRAC_ONE);
  c_sleep_run: cover property (@(posedge ref_clk_i) disable iff (!rstn_i)
    sleep_i && run && tick && state_reg == rcodiv_pkg::RCODIV_ST_ON);
endmodule : rcodiv_top

// ===== sim/rcodiv_ext_dev.sv
// model of an external device clocked from the reference output pin
// assumes the pin is a registered level synchronous to the core clock
`timescale 1ns/10ps
module rcodiv_ext_dev (
  input wire logic clk_i, // core clock, used only to time the pin
  input wire logic pin_i, // reference output pin level
  input wire logic pin_oe_i, // pin driven by the divider
  output logic [15:0] edges_o, // rising edges seen so far
  output logic [15:0] period_o // cycles between the last two rising edges
);
  logic last_q = 1'b0; // previous pin level
  logic [15:0] run_q = 16'h0000; // cycles since the last rising edge
  logic [15:0] edge_q = 16'h0000; // rising edges counted
  logic [15:0] per_q = 16'h0000; // last measured period
  // an undriven pin counts as low, so a stopped clock shows no edges
  logic pin_seen;
  assign pin_seen = pin_oe_i & pin_i;
  assign edges_o = edge_q;
  assign period_o = per_q;
  // edge counter and period meter
  always @(posedge clk_i) begin
    last_q <= pin_seen;
    run_q <= run_q + 16'h0001;
    if (pin_seen && !last_q) begin
      edge_q <= edge_q + 16'h0001;
      per_q <= run_q + 16'h0001;
      run_q <= 16'h0000;
    end
  end
endmodule : rcodiv_ext_dev

// ===== sim/rcodiv_tb_top.sv
// self-checking bench for the reference clock divider
// assumes base clock ticks made here: source k ticks every k+1 cycles
`timescale 1ns/10ps
`include "rcodiv_params.svh"
module rcodiv_tb_top;
  logic ref_clk_i = 1'b0; // 10 MHz
  logic rstn_i = 1'b0;
  logic [3:0] addr_i = 4'h0;
  logic [15:0] wdata_i = 16'h0000;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [15:0] rdata_o;
  logic [7:0] src_tick_i = 8'h00;
  logic idle_i = 1'b0;
  logic sleep_i = 1'b0;
  logic pkeep_i = 1'b0;
  logic skeep_i = 1'b0;
  logic pin_o, pin_oe_o;
  logic [15:0] edges, period;
  int n_errors = 0;
  int compares = 0;
  int tcnt = 0; // free-running tick counter
  rcodiv_top DUT (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .src_tick_i(src_tick_i), .idle_i(idle_i),
    .sleep_i(sleep_i), .primary_osc_keep_enable_i(pkeep_i),
    .secondary_osc_keep_enable_i(skeep_i), .reference_output_pin_o(pin_o),
    .reference_output_pin_oe_o(pin_oe_o));
  rcodiv_ext_dev ext (.clk_i(ref_clk_i), .pin_i(pin_o), .pin_oe_i(pin_oe_o),
    .edges_o(edges), .period_o(period));
  initial begin
    forever #50 ref_clk_i = ~ref_clk_i;
  end
  // distinct tick rates let the period tell which source is live
  always @(posedge ref_clk_i) begin
    tcnt <= tcnt + 1;
    for (int k = 0; k < 8; k++) src_tick_i[k] <= (tcnt % (k + 1) == 0);
  end
  task automatic tally_and_finish();
    $display("errors %0d, compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk
  // bus tasks: one-cycle strobes, a cycle of gap so no strobe is set twice in a step
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1;
    d = rdata_o;
  endtask : rd
  task automatic rchk(input logic [3:0] a, input logic [15:0] exp);
    logic [15:0] d;
    rd(a, d);
    chk("register", exp, d);
  endtask : rchk
  // bounded poll of one control bit
  task automatic wait_bit(input int b, input logic v);
    logic [15:0] d;
    int n;
    n = 0;
    do begin
      rd(`RCODIV_OFF_CTRL_LOW, d);
      n++;
    end while (d[b] !== v && n < 100);
    compares++;
    if (d[b] !== v) begin
      n_errors++;
      $display("unexpected ctrl bit %0d: expected %b, seen %b", b, v, d[b]);
      tally_and_finish();
    end
  endtask : wait_bit
  // settle, then count edges over a fixed window
  task automatic meas(output logic [15:0] d);
    logic [15:0] e0;
    repeat (40) @(posedge ref_clk_i);
    e0 = edges;
    repeat (60) @(posedge ref_clk_i);
    d = edges - e0;
  endtask : meas
  // source change: stop, wait for the handshake, select, restart
  task automatic set_cfg(input logic [3:0] s, input logic [15:0] bits);
    wr(`RCODIV_OFF_CTRL_LOW, bits | s);
    wait_bit(`RCODIV_BIT_REQUEST_STATUS, 1'b0);
    chk("pin after stop", 16'h0000, {15'h0, pin_o});
    wr(`RCODIV_OFF_CTRL_LOW, bits | s);
    wr(`RCODIV_OFF_CTRL_LOW, 16'h8000 | bits | s);
    wait_bit(`RCODIV_BIT_REQUEST_STATUS, 1'b1);
  endtask : set_cfg
  initial begin
    logic [15:0] d;
    int nn, tt, ex;
    int n_tab[3] = '{1, 3, 0};
    int t_tab[3] = '{0, 256, 256};
    logic [3:0] s_src[6] = '{4'h4, 4'h4, 4'h2, 4'h2, 4'h5, 4'h1};
    logic [3:0] s_bits[6] = '{4'b1100, 4'b0001, 4'b0100, 4'b1110, 4'b1101, 4'b0100};
    repeat (3) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    for (int a = 0; a < 4; a++) rchk(a[3:0], 16'h0000); // reset values, unmapped reads 0
    wr(`RCODIV_OFF_DIV_HIGH, 16'hffff);
    wr(`RCODIV_OFF_TRIM, 16'hffff);
    wr(4'h3, 16'h0000); // unmapped write ignored
    rchk(`RCODIV_OFF_DIV_HIGH, 16'h7fff);
    rchk(`RCODIV_OFF_TRIM, 16'hff80);
    wr(`RCODIV_OFF_DIV_HIGH, 16'h0000);
    wr(`RCODIV_OFF_TRIM, 16'h0000);
    set_cfg(4'h1, 16'h1000);
    rchk(`RCODIV_OFF_CTRL_LOW, 16'h9101);
    wr(`RCODIV_OFF_CTRL_LOW, 16'h9003); // refused while status set
    rchk(`RCODIV_OFF_CTRL_LOW, 16'h9101);
    for (int k = 0; k < 8; k++) begin
      set_cfg(k[3:0], 16'h1000);
      meas(d);
      if (k == 7) chk("dead source edges", 16'h0000, d);
      else chk("source period", 16'(2 * (k + 1)), period);
    end
    set_cfg(4'h1, 16'h1000);
    for (int i = 0; i < 3; i++) begin
      nn = n_tab[i];
      tt = t_tab[i];
      rchk(`RCODIV_OFF_CTRL_LOW, 16'h9101);
      wr(`RCODIV_OFF_DIV_HIGH, 16'(nn));
      wr(`RCODIV_OFF_TRIM, 16'(tt << 7));
      wr(`RCODIV_OFF_CTRL_LOW, 16'h9201);
      wait_bit(`RCODIV_BIT_SWITCH_ENABLE, 1'b0);
      meas(d);
      ex = 2 * (2 * ((nn > 0) ? nn : 1) + ((nn > 0 && tt == 256) ? 1 : 0));
      chk("divided period", 16'(ex), period);
    end
    wr(`RCODIV_OFF_CTRL_LOW, 16'h8001);
    meas(d);
    chk("edges with pin off", 16'h0000, d);
    chk("pin enable", 16'h0000, {15'h0, pin_oe_o});
    wr(`RCODIV_OFF_CTRL_LOW, 16'h9001);
    @(posedge ref_clk_i);
    #1;
    chk("pin enable", 16'h0001, {15'h0, pin_oe_o});
    @(posedge ref_clk_i);
    idle_i <= 1'b1;
    meas(d);
    chk("idle running", 16'h0001, {15'h0, d != 0});
    wr(`RCODIV_OFF_CTRL_LOW, 16'hb001);
    meas(d);
    chk("idle stopped", 16'h0000, d);
    idle_i <= 1'b0;
    // bits: alive, run_in_sleep, primary keep, secondary keep
    for (int i = 0; i < 6; i++) begin
      set_cfg(s_src[i], s_bits[i][2] ? 16'h1800 : 16'h1000);
      pkeep_i <= s_bits[i][1];
      skeep_i <= s_bits[i][0];
      @(posedge ref_clk_i);
      sleep_i <= 1'b1;
      meas(d);
      chk("sleep output alive", {15'h0, s_bits[i][3]}, {15'h0, d != 0});
      if (s_bits[i][3]) chk("sleep period", 16'(2 * (s_src[i] + 1)), period);
      sleep_i <= 1'b0;
    end
    tally_and_finish();
  end
endmodule : rcodiv_tb_top
